// [hdl/mmrd_map.svh]
`ifndef MMRD_MAP_SVH
`define MMRD_MAP_SVH
// serial timing
`define MMRD_CLK_NS      50
`define MMRD_BIT_NS      32000
`define MMRD_BIT_CYC     ((`MMRD_BIT_NS + `MMRD_CLK_NS - 1) / `MMRD_CLK_NS)
// register offsets
`define MMRD_REG_CTRL    4'h0
`define MMRD_REG_FLAGS   4'h1
`define MMRD_REG_MAIN    4'h2
`define MMRD_REG_SUBMIX  4'h3
`define MMRD_REG_NAV     4'h4
`define MMRD_REG_REC     4'h5
`define MMRD_REG_BLOCK   4'h6
`define MMRD_REG_PRESET  4'h7
// control bit positions and reset value
`define MMRD_CTRL_SA     0
`define MMRD_CTRL_RC     1
`define MMRD_CTRL_HOST   2
`define MMRD_CTRL_RST    3'h0
// note numbers on channel 1
`define MMRD_NOTE_DIM    7'h5D
`define MMRD_NOTE_TALK   7'h5E
`define MMRD_NOTE_RECALL 7'h5F
`define MMRD_NOTE_MONO   7'h2A
`define MMRD_NOTE_SPKB   7'h32
`define MMRD_NOTE_CUE0   7'h3E
`define MMRD_NOTE_CUE4   7'h42
`define MMRD_NOTE_SNAP0  7'h36
`define MMRD_NOTE_SNAP7  7'h3D
`define MMRD_NOTE_SETUP5 7'h3B
`define MMRD_NOTE_TRIM   7'h2D
`define MMRD_NOTE_MUTE   7'h2C
`define MMRD_NOTE_SOLO   7'h2B
// controllers and values
`define MMRD_CC_VOLUME   7'h07
`define MMRD_CC_GAIN     7'h09
`define MMRD_CC_PRESET   7'h0C
`define MMRD_CC_FADER0   7'h66
`define MMRD_CC_FADER15  7'h75
`define MMRD_CC_SUB0     7'h68
`define MMRD_CC_SUB15    7'h77
`define MMRD_GAIN_MAX    7'h41
`define MMRD_UNITY       7'h68
`define MMRD_COL_MAX     6'h38
`endif

// [hdl/mmrd_pkg.sv]
package mmrd_pkg;
	typedef enum logic [1:0] {
		UART_IDLE  = 2'b00,
		UART_START = 2'b01,
		UART_DATA  = 2'b10,
		UART_STOP  = 2'b11
	} mmrd_uart_state_type;
	typedef struct packed {
		logic solo;
		logic mute;
		logic trim;
		logic speaker_b;
		logic mono;
		logic recall;
		logic talkback;
		logic dim;
	} mmrd_flags_type;
endpackage

// [hdl/mmrd_uart_rx.sv]
`timescale 1ns/100ps
`include "mmrd_map.svh"
module mmrd_uart_rx #(
	parameter int BIT_CYCLES = `MMRD_BIT_CYC
)(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       rx_pin,
	output logic            byte_valid,
	output logic [7:0]      byte_data
);
	import mmrd_pkg::*;
	localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);
	logic                sync1_r;
	logic                sync2_r;
	logic [15:0]         cnt_r;
	logic [2:0]          bit_r;
	mmrd_uart_state_type state_r;

	generate if (BIT_CYCLES < 8 || BIT_CYCLES > 65535) begin : g_chk
		$error("BIT_CYCLES out of range");
	end endgenerate

	// two-stage pin synchroniser
	always_ff @(posedge mclk) begin
		sync1_r <= rst_n ? rx_pin : 1'b1;
		sync2_r <= rst_n ? sync1_r : 1'b1;
	end

	// mid-bit sampling, framing check on stop bit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r    <= UART_IDLE;
			cnt_r      <= '0;
			bit_r      <= '0;
			byte_data  <= '0;
			byte_valid <= 1'b0;
		end else begin
			byte_valid <= 1'b0;
			if (state_r != UART_IDLE && cnt_r != 16'h0000) begin
				cnt_r <= cnt_r - 16'h0001;
			end else begin
				cnt_r <= FULL;
				case (state_r)
					UART_IDLE: if (!sync2_r) begin
						state_r <= UART_START;
						cnt_r   <= HALF;
					end
					UART_START: state_r <= sync2_r ? UART_IDLE : UART_DATA;
					UART_DATA: begin
						byte_data <= {sync2_r, byte_data[7:1]};
						bit_r     <= bit_r + 3'h1;
						if (bit_r == 3'h7) state_r <= UART_STOP;
					end
					UART_STOP: begin
						byte_valid <= sync2_r;
						state_r    <= UART_IDLE;
					end
					default: state_r <= UART_IDLE;
				endcase
			end
		end
	end
endmodule

// [hdl/mmrd_uart_tx.sv]
`timescale 1ns/100ps
`include "mmrd_map.svh"
module mmrd_uart_tx #(
	parameter int BIT_CYCLES = `MMRD_BIT_CYC
)(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       send,
	input  wire logic [7:0] send_data,
	output logic            busy,
	output logic            tx_pin
);
	import mmrd_pkg::*;
	localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
	logic [15:0]         cnt_r;
	logic [2:0]          bit_r;
	logic [7:0]          shift_r;
	mmrd_uart_state_type state_r;

	generate if (BIT_CYCLES < 8 || BIT_CYCLES > 65535) begin : g_chk
		$error("BIT_CYCLES out of range");
	end endgenerate

	assign busy = (state_r != UART_IDLE);

	// start, eight data bits lsb first, stop
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= UART_IDLE;
			cnt_r   <= '0;
			bit_r   <= '0;
			shift_r <= '0;
			tx_pin  <= 1'b1;
		end else if (state_r == UART_IDLE) begin
			if (send) begin
				shift_r <= send_data;
				cnt_r   <= FULL;
				tx_pin  <= 1'b0;
				state_r <= UART_START;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else begin
			cnt_r <= FULL;
			case (state_r)
				UART_START, UART_DATA: begin
					tx_pin  <= shift_r[0];
					shift_r <= {1'b1, shift_r[7:1]};
					if (state_r == UART_START) begin
						state_r <= UART_DATA;
					end else begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) state_r <= UART_STOP;
					end
				end
				UART_STOP: state_r <= UART_IDLE;
				default: state_r <= UART_IDLE;
			endcase
		end
	end
endmodule

// [hdl/mmrd_top.sv]
`timescale 1ns/100ps
`include "mmrd_map.svh"
// Summary of operation
// - volume controller on channel 1 sets the primary main output level
// - channel 1 notes 5D, 5E, 5F drive dim, talkback and recall
// - channel 1 notes 2A and 32 drive mono and alternate speakers
// - note 3E cues main output, notes 3F to 42 cue phones 1 to 4
// - notes 36 to 3D recall snapshots 1 to 8
// - notes 2D, 2C, 2B drive trim mode, master mute, master solo
// - fader messages are three bytes: status Bx, controller, value
// - channels 1-4 first row, 5-8 middle row, 9-12 bottom row
// - controllers 102-117 are sixteen faders, channel picks group, 64 per row
// - value 68 is unity, 0 full attenuation, 7F maximum
// - channel 13 controller 66 toggles trim mode; submix select ends it unless a note or the toggle arrives that cycle
// - channel 13 controllers from 68 pick the bottom-row submix
// - controller 9 sets input gain up to 65 on channels 9-12 when enabled
// - controller 0C on channel 3 picks reverb preset, on channel 4 echo
// - remote control always works in submix view
// - stand-alone enable governs answering notes and sending notes
// - stand-alone keeps rows one and three, mute, select, submix; skips row two
// - stand-alone ignores talkback, mono, solo and monitor commands
// - stand-alone sends brief position and led data, never names or meters
// - fader block moves by one or eight channels and by rows
// - strip record buttons select the output bus of that strip
// - stand-alone notes 36 to 3B load device setups 1 to 6
module mmrd_top #(
	parameter int         BIT_CYCLES = `MMRD_BIT_CYC,
	parameter logic [3:0] GAIN_FIRST = 4'h8,
	parameter logic [3:0] GAIN_LAST  = 4'hB
)(
	input  wire logic            mclk,
	input  wire logic            rst_n,
	input  wire logic            midi_rx,
	output logic                 midi_tx,
	input  wire logic [3:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_we,
	input  wire logic            reg_re,
	output logic [7:0]           reg_rdata,
	output mmrd_pkg::mmrd_flags_type mixer_flags,
	output logic [6:0]           main_level,
	output logic                 fader_we,
	output logic [1:0]           fader_row,
	output logic [5:0]           fader_index,
	output logic [6:0]           fader_value,
	output logic                 fader_unity,
	output logic [3:0]           submix_sel,
	output logic [2:0]           cue_sel,
	output logic                 recall_we,
	output logic                 recall_setup,
	output logic [2:0]           recall_num,
	output logic                 gain_we,
	output logic [3:0]           gain_input,
	output logic [6:0]           gain_value,
	output logic [3:0]           reverb_preset,
	output logic [3:0]           echo_preset,
	output logic [1:0]           block_row,
	output logic [5:0]           block_col
);
	import mmrd_pkg::*;

	generate if (GAIN_FIRST > GAIN_LAST) begin : g_chk
		$error("gain channel range reversed");
	end endgenerate
	logic       rx_valid;
	logic [7:0] rx_byte;
	logic       tx_busy;
	logic       tx_send;
	logic [7:0] tx_byte;
	logic [2:0] ctrl_r;
	logic [7:0] run_status_r;
	logic [6:0] first_r;
	logic       have_first_r;
	logic       msg_r;
	logic [7:0] st_r;
	logic [6:0] d1_r;
	logic [6:0] d2_r;
	logic       disp_req_r;
	logic       led_req_r;
	logic [6:0] led_note_r;
	logic [6:0] led_val_r;
	logic [1:0] tx_idx_r;
	logic [7:0] tx_b1_r;
	logic [7:0] tx_b2_r;
	logic       standalone_remote_enable;
	logic       remote_control_enable;
	logic       act;
	logic [3:0] ch;
	logic       is_cc;
	logic       note_hit;
	logic       cc_trim;
	logic       cc_submix;
	logic       fader_hit;
	logic [1:0] hit_row;
	logic       nav_we;
	logic       rec_we;
	logic [5:0] step;
	mmrd_uart_rx #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_rx (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.rx_pin     (midi_rx),
		.byte_valid (rx_valid),
		.byte_data  (rx_byte)
	);
	mmrd_uart_tx #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_tx (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.send      (tx_send),
		.send_data (tx_byte),
		.busy      (tx_busy),
		.tx_pin    (midi_tx)
	);
	// control register and register-bus strobes
	assign standalone_remote_enable = ctrl_r[`MMRD_CTRL_SA];
	assign remote_control_enable    = ctrl_r[`MMRD_CTRL_RC];
	assign nav_we = reg_we && reg_addr == `MMRD_REG_NAV;
	assign rec_we = reg_we && reg_addr == `MMRD_REG_REC;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_r <= `MMRD_CTRL_RST;
		end else if (reg_we && reg_addr == `MMRD_REG_CTRL) begin
			ctrl_r <= reg_wdata[2:0];
		end
	end
	// read data, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_re) begin
			case (reg_addr)
				`MMRD_REG_CTRL:   reg_rdata <= {5'h00, ctrl_r};
				`MMRD_REG_FLAGS:  reg_rdata <= mixer_flags;
				`MMRD_REG_MAIN:   reg_rdata <= {1'b0, main_level};
				`MMRD_REG_SUBMIX: reg_rdata <= {1'b0, cue_sel, submix_sel};
				`MMRD_REG_BLOCK:  reg_rdata <= {block_row, block_col};
				`MMRD_REG_PRESET: reg_rdata <= {echo_preset, reverb_preset};
				default:          reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
	// byte parser with running status; realtime bytes pass untouched
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_status_r <= 8'h00;
			first_r      <= '0;
			have_first_r <= 1'b0;
			msg_r        <= 1'b0;
			st_r         <= 8'h00;
			d1_r         <= '0;
			d2_r         <= '0;
		end else begin
			msg_r <= 1'b0;
			if (rx_valid && rx_byte < 8'hF8) begin
				if (rx_byte[7]) begin
					run_status_r <= (rx_byte < 8'hF0) ? rx_byte : 8'h00;
					have_first_r <= 1'b0;
				end else if (run_status_r != 8'h00) begin
					if (run_status_r[7:5] == 3'b110) begin
						have_first_r <= 1'b0; // two-byte kinds dropped
					end else if (!have_first_r) begin
						first_r      <= rx_byte[6:0];
						have_first_r <= 1'b1;
					end else begin
						have_first_r <= 1'b0;
						msg_r        <= 1'b1;
						st_r         <= run_status_r;
						d1_r         <= first_r;
						d2_r         <= rx_byte[6:0];
					end
				end
			end
		end
	end
	// message classification
	assign act      = standalone_remote_enable || (ctrl_r[`MMRD_CTRL_HOST] && remote_control_enable);
	assign ch       = st_r[3:0];
	assign is_cc    = msg_r && act && st_r[7:4] == 4'hB;
	assign note_hit = msg_r && act && st_r == 8'h90 && d2_r != 7'h00;
	assign cc_trim  = is_cc && ch == 4'hC && d1_r == `MMRD_CC_FADER0;
	assign cc_submix = is_cc && ch == 4'hC && d1_r >= `MMRD_CC_SUB0 && d1_r <= `MMRD_CC_SUB15;
	assign hit_row  = ch[3:2];
	assign fader_hit = is_cc && ch < 4'hC && d1_r >= `MMRD_CC_FADER0 && d1_r <= `MMRD_CC_FADER15
		&& !(standalone_remote_enable && hit_row == 2'h1);

	// toggled mixer functions on channel 1 notes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mixer_flags <= '0;
		end else if (note_hit) begin
			case (d1_r)
				`MMRD_NOTE_DIM:    mixer_flags.dim <= ~mixer_flags.dim;
				`MMRD_NOTE_TALK:   if (!standalone_remote_enable) mixer_flags.talkback <= ~mixer_flags.talkback;
				`MMRD_NOTE_RECALL: mixer_flags.recall <= ~mixer_flags.recall;
				`MMRD_NOTE_MONO:   if (!standalone_remote_enable) mixer_flags.mono <= ~mixer_flags.mono;
				`MMRD_NOTE_SPKB:   mixer_flags.speaker_b <= ~mixer_flags.speaker_b;
				`MMRD_NOTE_TRIM:   mixer_flags.trim <= ~mixer_flags.trim;
				`MMRD_NOTE_MUTE:   mixer_flags.mute <= ~mixer_flags.mute;
				`MMRD_NOTE_SOLO:   if (!standalone_remote_enable) mixer_flags.solo <= ~mixer_flags.solo;
				default: ;
			endcase
		end else if (cc_trim) begin
			mixer_flags.trim <= ~mixer_flags.trim;
		end else if (cc_submix || (rec_we && reg_wdata[7:3] == 5'h00)) begin
			mixer_flags.trim <= 1'b0;
		end
	end

	// cue of main output or phones mixes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cue_sel <= '0;
		end else if (note_hit && !standalone_remote_enable
			&& d1_r >= `MMRD_NOTE_CUE0 && d1_r <= `MMRD_NOTE_CUE4) begin
			cue_sel <= 3'(d1_r - `MMRD_NOTE_CUE0);
		end
	end

	// snapshot recall, or device setup load in stand-alone
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			recall_we    <= 1'b0;
			recall_setup <= 1'b0;
			recall_num   <= '0;
		end else begin
			recall_we <= 1'b0;
			if (note_hit && d1_r >= `MMRD_NOTE_SNAP0 && d1_r <= `MMRD_NOTE_SNAP7) begin
				if (!standalone_remote_enable || d1_r <= `MMRD_NOTE_SETUP5) begin
					recall_we    <= 1'b1;
					recall_setup <= standalone_remote_enable;
					recall_num   <= 3'(d1_r - `MMRD_NOTE_SNAP0);
				end
			end
		end
	end

	// fader writes, always relative to the current submix
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fader_we    <= 1'b0;
			fader_row   <= '0;
			fader_index <= '0;
			fader_value <= '0;
			fader_unity <= 1'b0;
		end else begin
			fader_we <= fader_hit;
			if (fader_hit) begin
				fader_row   <= hit_row;
				fader_index <= {ch[1:0], 4'(d1_r - `MMRD_CC_FADER0)};
				fader_value <= d2_r;
				fader_unity <= (d2_r == `MMRD_UNITY);
			end
		end
	end

	// main output volume
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			main_level <= '0;
		end else if (is_cc && ch == 4'h0 && d1_r == `MMRD_CC_VOLUME) begin
			main_level <= d2_r;
		end else if (reg_we && reg_addr == `MMRD_REG_MAIN) begin
			main_level <= reg_wdata[6:0];
		end
	end

	// input gain
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gain_we    <= 1'b0;
			gain_input <= '0;
			gain_value <= '0;
		end else begin
			gain_we <= 1'b0;
			if (is_cc && remote_control_enable && d1_r == `MMRD_CC_GAIN && ch >= GAIN_FIRST
				&& ch <= GAIN_LAST && d2_r <= `MMRD_GAIN_MAX) begin
				gain_we    <= 1'b1;
				gain_input <= ch;
				gain_value <= d2_r;
			end
		end
	end

	// effect user presets, value 0 meaning preset 1
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reverb_preset <= '0;
			echo_preset   <= '0;
		end else if (is_cc && d1_r == `MMRD_CC_PRESET && d2_r < 7'h10) begin
			if (ch == 4'h2) reverb_preset <= d2_r[3:0];
			if (ch == 4'h3) echo_preset <= d2_r[3:0];
		end
	end

	// current submix from controller or strip record button
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			submix_sel <= '0;
		end else if (cc_submix) begin
			submix_sel <= 4'(d1_r - `MMRD_CC_SUB0);
		end else if (rec_we && reg_wdata[7:3] == 5'h00) begin
			submix_sel <= 4'(block_col + {3'h0, reg_wdata[2:0]});
		end
	end

	// fader block navigation
	assign step = reg_wdata[1] ? 6'h08 : 6'h01;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			block_row <= '0;
			block_col <= '0;
		end else if (nav_we) begin
			case (reg_wdata[2:0])
				3'h0, 3'h2: block_col <= (block_col < step) ? 6'h00 : block_col - step;
				3'h1, 3'h3: block_col <= (block_col > `MMRD_COL_MAX - step) ? `MMRD_COL_MAX : block_col + step;
				3'h4: if (block_row != 2'h0) block_row <= (standalone_remote_enable) ? 2'h0 : block_row - 2'h1;
				3'h5: if (block_row != 2'h2) block_row <= (standalone_remote_enable) ? 2'h2 : block_row + 2'h1;
				default: ;
			endcase
		end
	end

	// feedback requests; a new request beats the clear of the old one
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			disp_req_r <= 1'b0;
			led_req_r  <= 1'b0;
			led_note_r <= '0;
			led_val_r  <= '0;
		end else begin
			if (tx_idx_r == 2'h0 && !tx_busy) begin
				if (disp_req_r) disp_req_r <= 1'b0;
				else led_req_r <= 1'b0;
			end
			if (standalone_remote_enable && nav_we) disp_req_r <= 1'b1;
			if (standalone_remote_enable && note_hit && d1_r == `MMRD_NOTE_DIM) begin
				led_req_r  <= 1'b1;
				led_note_r <= d1_r;
				led_val_r  <= mixer_flags.dim ? 7'h00 : 7'h7F;
			end
		end
	end

	// three-byte sender: brief position or led state only
	assign tx_send = !tx_busy && (tx_idx_r != 2'h0 || disp_req_r || led_req_r);
	assign tx_byte = (tx_idx_r == 2'h1) ? tx_b1_r :
		(tx_idx_r == 2'h2) ? tx_b2_r :
		disp_req_r ? 8'hBF : 8'h90;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_idx_r <= '0;
			tx_b1_r  <= '0;
			tx_b2_r  <= '0;
		end else if (tx_send) begin
			tx_idx_r <= (tx_idx_r == 2'h2) ? 2'h0 : tx_idx_r + 2'h1;
			if (tx_idx_r == 2'h0) begin
				tx_b1_r <= disp_req_r ? {6'h00, block_row} : {1'b0, led_note_r};
				tx_b2_r <= disp_req_r ? {2'h0, block_col} : {1'b0, led_val_r};
			end
		end
	end
endmodule

// [tb/mmrd_top_monitor.sv]
`timescale 1ns/100ps
`include "mmrd_map.svh"
// watches the decoder's ports for timing and range slips
module mmrd_top_monitor #(
	parameter logic [3:0] GAIN_FIRST = 4'h8,
	parameter logic [3:0] GAIN_LAST  = 4'hB
)(
	input wire logic                 mclk,
	input wire logic                 rst_n,
	input wire logic                 midi_tx,
	input wire logic [3:0]           reg_addr,
	input wire logic [7:0]           reg_wdata,
	input wire logic                 reg_we,
	input wire logic                 reg_re,
	input wire logic [7:0]           reg_rdata,
	input mmrd_pkg::mmrd_flags_type  mixer_flags,
	input wire logic                 fader_we,
	input wire logic [1:0]           fader_row,
	input wire logic [6:0]           fader_value,
	input wire logic                 fader_unity,
	input wire logic [2:0]           cue_sel,
	input wire logic                 recall_we,
	input wire logic                 recall_setup,
	input wire logic [2:0]           recall_num,
	input wire logic                 gain_we,
	input wire logic [3:0]           gain_input,
	input wire logic [6:0]           gain_value,
	input wire logic [5:0]           block_col
);
	import mmrd_pkg::*;
	logic sa_r;
	// follows the stand-alone enable bit written over the register port
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sa_r <= 1'b0;
		end else if (reg_we && reg_addr == `MMRD_REG_CTRL) begin
			sa_r <= reg_wdata[`MMRD_CTRL_SA];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// relations between inputs and decoded outputs
	unmapped_read_a: assert property (reg_re && reg_addr > 4'h7 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	fader_pulse_a: assert property (fader_we |=> !fader_we)
		else $error("fader strobe too long");
	unity_flag_a: assert property (fader_we |-> fader_unity == (fader_value == 7'h68))
		else $error("unity flag wrong");
	fader_row_a: assert property (fader_we |-> fader_row != 2'h3 && !(sa_r && fader_row == 2'h1))
		else $error("bad fader row");
	gain_range_a: assert property (gain_we |-> gain_value <= 7'h41 && gain_input >= GAIN_FIRST && gain_input <= GAIN_LAST)
		else $error("gain out of range");
	recall_kind_a: assert property (recall_we |-> recall_setup == sa_r && (!recall_setup || recall_num <= 3'h5))
		else $error("bad recall");
	block_col_a: assert property (block_col <= 6'h38)
		else $error("block column too far");
	cue_range_a: assert property (cue_sel <= 3'h4)
		else $error("cue out of range");
	tx_quiet_a: assert property (!sa_r |-> midi_tx)
		else $error("transmit while stand-alone off");
	trim_clear_a: assert property (reg_we && reg_addr == 4'h5 && reg_wdata <= 8'h07 |=> !mixer_flags.trim)
		else $error("trim not cleared by submix select");
	// main scenarios reached
	cover property (fader_we && fader_unity);
	cover property (recall_we && recall_setup);
	cover property (gain_we);
	cover property (!midi_tx);
endmodule
bind mmrd_top mmrd_top_monitor #(.GAIN_FIRST(GAIN_FIRST), .GAIN_LAST(GAIN_LAST)) u_monitor (
	.mclk(mclk), .rst_n(rst_n), .midi_tx(midi_tx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .mixer_flags(mixer_flags),
	.fader_we(fader_we), .fader_row(fader_row), .fader_value(fader_value), .fader_unity(fader_unity),
	.cue_sel(cue_sel), .recall_we(recall_we), .recall_setup(recall_setup), .recall_num(recall_num),
	.gain_we(gain_we), .gain_input(gain_input), .gain_value(gain_value), .block_col(block_col));

// [tb/mmrd_midi_ctrl.sv]
`timescale 1ns/100ps
// behavioural controller: sends messages, collects device bytes
module mmrd_midi_ctrl #(
	parameter int BIT_CYCLES = 16
)(
	input  wire logic mclk,
	output logic      midi_rx,
	input  wire logic midi_tx
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_b;
	logic [9:0] frame;
	// line idles high between frames
	initial midi_rx = 1'b1;
	// start bit, data lsb first, stop bit
	task automatic send_byte(input logic [7:0] b);
		frame = {1'b1, b, 1'b0};
		@(posedge mclk);
		for (int i = 0; i < 10; i++) begin
			midi_rx <= frame[i];
			repeat (BIT_CYCLES) @(posedge mclk);
		end
	endtask
	// status with channel minus one in low nibble, then two data bytes
	task automatic send_msg(input logic [7:0] st, input logic [7:0] d1, input logic [7:0] d2);
		send_byte(st);
		send_byte(d1);
		send_byte(d2);
	endtask
	// samples device bytes in mid-bit
	always begin
		@(posedge mclk);
		if (midi_tx === 1'b0) begin
			repeat (BIT_CYCLES / 2) @(posedge mclk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge mclk);
				rx_b[i] = midi_tx;
			end
			repeat (BIT_CYCLES) @(posedge mclk);
			rx_q.push_back(rx_b);
		end
	end
endmodule

// [tb/midi_mixer_remote_decoder_tb.sv]
`timescale 1ns/100ps
`include "mmrd_map.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module midi_mixer_remote_decoder_tb;
	import mmrd_pkg::*;
	logic           mclk, rst_n, midi_rx, midi_tx, reg_we, reg_re, fader_we, fader_unity;
	logic           recall_we, recall_setup, gain_we;
	logic [3:0]     reg_addr, submix_sel, gain_input, reverb_preset, echo_preset;
	logic [7:0]     reg_wdata, reg_rdata, rd;
	logic [6:0]     main_level, fader_value, gain_value;
	logic [1:0]     fader_row, block_row;
	logic [5:0]     fader_index, block_col;
	logic [2:0]     cue_sel, recall_num;
	logic [15:0]    fader_last;
	logic [3:0]     recall_last;
	logic [10:0]    gain_last;
	mmrd_flags_type mixer_flags;
	int             num_errors, comparisons, fader_cnt, recall_cnt, gain_cnt;
	mmrd_top #(.BIT_CYCLES(16)) DUT (
		.mclk(mclk), .rst_n(rst_n), .midi_rx(midi_rx), .midi_tx(midi_tx), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.mixer_flags(mixer_flags), .main_level(main_level), .fader_we(fader_we), .fader_row(fader_row),
		.fader_index(fader_index), .fader_value(fader_value), .fader_unity(fader_unity),
		.submix_sel(submix_sel), .cue_sel(cue_sel), .recall_we(recall_we), .recall_setup(recall_setup),
		.recall_num(recall_num), .gain_we(gain_we), .gain_input(gain_input), .gain_value(gain_value),
		.reverb_preset(reverb_preset), .echo_preset(echo_preset), .block_row(block_row), .block_col(block_col));
	mmrd_midi_ctrl #(.BIT_CYCLES(16)) ctrl_model (.mclk(mclk), .midi_rx(midi_rx), .midi_tx(midi_tx));
	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// counts strobes and keeps what they carried
	always @(posedge mclk) begin
		if (fader_we === 1'b1) begin
			fader_cnt++;
			fader_last = {fader_row, fader_index, fader_value, fader_unity};
		end
		if (recall_we === 1'b1) begin
			recall_cnt++;
			recall_last = {recall_setup, recall_num};
		end
		if (gain_we === 1'b1) begin
			gain_cnt++;
			gain_last = {gain_input, gain_value};
		end
	end
	task automatic print_verdict();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge mclk);
		reg_we <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge mclk);
		reg_re <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// whole message, then time for the three-cycle answer to land
	task automatic msg(input logic [7:0] s, input logic [7:0] d1, input logic [7:0] d2);
		ctrl_model.send_msg(s, d1, d2);
		repeat (12) @(posedge mclk);
		#1;
	endtask
	// waits for three bytes from the device and checks them
	task automatic get_tx(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		int n;
		n = 0;
		while (ctrl_model.rx_q.size() < 3 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		if (n == 2000) begin
			`CHK(n, 0)
			print_verdict();
		end
		rd = ctrl_model.rx_q.pop_front();
		`CHK(rd, e0)
		rd = ctrl_model.rx_q.pop_front();
		`CHK(rd, e1)
		rd = ctrl_model.rx_q.pop_front();
		`CHK(rd, e2)
	endtask
	task automatic t_reset();
		`CHK(midi_tx, 1'b1)
		reg_wr(4'h9, 8'h5A);
		reg_rd(4'h9, rd);
		`CHK(rd, 8'h00)
		msg(8'h90, 8'h5D, 8'h7F);
		`CHK(mixer_flags, 8'h00)
	endtask
	task automatic t_notes();
		logic [7:0] notes [8] = '{8'h5D, 8'h5E, 8'h5F, 8'h2A, 8'h32, 8'h2D, 8'h2C, 8'h2B};
		reg_wr(`MMRD_REG_CTRL, 8'h06);
		for (int i = 0; i < 8; i++) begin
			msg(8'h90, notes[i], 8'h40);
			`CHK(mixer_flags, 8'((2 << i) - 1))
		end
		msg(8'h90, 8'h5D, 8'h00);
		msg(8'h80, 8'h5D, 8'h40);
		msg(8'h91, 8'h5D, 8'h7F);
		reg_rd(`MMRD_REG_FLAGS, rd);
		`CHK(rd, 8'hFF)
	endtask
	task automatic t_submix();
		reg_wr(`MMRD_REG_REC, 8'h03);
		`CHK(submix_sel, 4'h3)
		`CHK(mixer_flags.trim, 1'b0)
		msg(8'hBC, 8'h66, 8'h11);
		`CHK(mixer_flags.trim, 1'b1)
		msg(8'hBC, 8'h69, 8'h00);
		`CHK(submix_sel, 4'h1)
		`CHK(mixer_flags.trim, 1'b0)
		reg_wr(`MMRD_REG_REC, 8'h08);
		`CHK(submix_sel, 4'h1)
	endtask
	task automatic t_cue_snap();
		for (int i = 0; i < 5; i++) begin
			msg(8'h90, 8'(8'h3E + i), 8'h7F);
			`CHK(cue_sel, 3'(i))
		end
		recall_cnt = 0;
		for (int i = 0; i < 8; i++) begin
			msg(8'h90, 8'(8'h36 + i), 8'h7F);
			`CHK(recall_last, 4'(i))
		end
		`CHK(recall_cnt, 8)
	endtask
	task automatic t_faders();
		logic [23:0] m [8] = '{24'hB06668, 24'hB16600, 24'hB4667F, 24'hB87568, 24'hBB7567,
			24'hB07610, 24'hBD6610, 24'hB06510};
		logic [15:0] e [5] = '{16'h00D1, 16'h1000, 16'h40FE, 16'h8FD1, 16'hBFCE};
		for (int i = 0; i < 8; i++) begin
			fader_cnt = 0;
			msg(m[i][23:16], m[i][15:8], m[i][7:0]);
			`CHK(fader_cnt, int'(i < 5))
			if (i < 5) `CHK(fader_last, e[i])
		end
	endtask
	task automatic t_levels();
		msg(8'hB0, 8'h07, 8'h55);
		msg(8'hB1, 8'h07, 8'h22);
		`CHK(main_level, 7'h55)
		gain_cnt = 0;
		msg(8'hB8, 8'h09, 8'h41);
		`CHK(gain_last, {4'h8, 7'h41})
		msg(8'hBB, 8'h09, 8'h00);
		`CHK(gain_last, {4'hB, 7'h00})
		msg(8'hB8, 8'h09, 8'h42);
		msg(8'hB7, 8'h09, 8'h10);
		`CHK(gain_cnt, 2)
		msg(8'hB2, 8'h0C, 8'h05);
		msg(8'hB3, 8'h0C, 8'h0F);
		msg(8'hB2, 8'h0C, 8'h10);
		reg_rd(`MMRD_REG_PRESET, rd);
		`CHK(rd, 8'hF5)
	endtask
	task automatic t_standalone();
		reg_wr(`MMRD_REG_CTRL, 8'h01);
		msg(8'h90, 8'h5E, 8'h7F);
		msg(8'h90, 8'h2A, 8'h7F);
		msg(8'h90, 8'h2B, 8'h7F);
		msg(8'h90, 8'h3F, 8'h7F);
		`CHK(mixer_flags, 8'hDF)
		`CHK(cue_sel, 3'h4)
		recall_cnt = 0;
		fader_cnt = 0;
		gain_cnt = 0;
		msg(8'h90, 8'h3B, 8'h7F);
		msg(8'h90, 8'h3C, 8'h7F);
		`CHK(recall_cnt, 1)
		`CHK(recall_last, 4'hD)
		msg(8'hB4, 8'h66, 8'h10);
		msg(8'hB8, 8'h66, 8'h10);
		msg(8'hB8, 8'h09, 8'h10);
		`CHK(fader_cnt, 1)
		`CHK(gain_cnt, 0)
		ctrl_model.rx_q.delete();
		reg_wr(`MMRD_REG_NAV, 8'h03);
		get_tx(8'hBF, 8'h00, 8'h08);
		msg(8'h90, 8'h5D, 8'h7F);
		get_tx(8'h90, 8'h5D, 8'h00);
		reg_wr(`MMRD_REG_NAV, 8'h00);
		reg_wr(`MMRD_REG_NAV, 8'h02);
		reg_wr(`MMRD_REG_NAV, 8'h05);
		`CHK(block_col, 6'h00)
		`CHK(block_row, 2'h2)
	endtask
	// reset, then every scenario in turn
	initial begin
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		t_reset();
		t_notes();
		t_submix();
		t_cue_snap();
		t_faders();
		t_levels();
		t_standalone();
		print_verdict();
	end
endmodule
